// File: tb/cbs_host.sv
`timescale 1ns/1ns
module cbs_host
(
  // clock
  input wire logic mclk,
  // bus lines
  input wire logic sda_wire,
  output logic scl_drv,
  output logic sda_drv
);
  int qn = 2;
  // ====
  // both lines released while idle or powered down
  initial
  begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  task q;
    repeat (qn) @(posedge mclk);
  endtask
  task bit_io(input logic b, output logic r);
    sda_drv <= b;
    q;
    scl_drv <= 1'b1;
    q;
    r = sda_wire;
    q;
    scl_drv <= 1'b0;
    q;
  endtask
  task frame_start;
    sda_drv <= 1'b1;
    scl_drv <= 1'b1;
    q;
    sda_drv <= 1'b0;
    q;
    scl_drv <= 1'b0;
    q;
  endtask
  task frame_stop;
    sda_drv <= 1'b0;
    q;
    scl_drv <= 1'b1;
    q;
    sda_drv <= 1'b1;
    q;
  endtask
  task byte_io(input logic [7:0] d, input logic ai, output logic [7:0] r,
    output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r[i]);
    end
    bit_io(ai, a);
    ack = !a;
  endtask
endmodule // cbs_host

// File: tb/clock_buffer_smbus_control_tb.sv
`timescale 1ns/1ns
`include "cbs_cfg.svh"
module clock_buffer_smbus_control_tb;
  logic mclk = 0, sys_rst = 1, inv = 0, en0 = 0, en3 = 0;
  logic stop_n = 1, pdn_n = 1, pll_pin = 1, bw_pin = 1, ack;
  logic sda_out, sda_oe_n, scl_drv, sda_drv, full_rate, pll_path, low_bw;
  logic [3:0] pair_run, pair_float;
  logic [7:0] rd, mode;
  logic [31:0] seed = 32'd17;
  int n_fail = 0, checks_done = 0;
  wire sda_wire = sda_drv & (sda_oe_n | sda_out);
  wire [15:0] outs = {pair_run, pair_float, 5'h0, low_bw, pll_path, full_rate};
  initial forever #20 mclk = ~mclk;
  cbs_control i_dut(.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl_drv),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .enable_pair0(en0), .enable_pair3(en3), .control_polarity_invert(inv),
    .clock_stop_n(stop_n), .power_down_n(pdn_n), .pll_select_pin(pll_pin),
    .loop_bandwidth_select(bw_pin), .pair_run(pair_run),
    .pair_float(pair_float), .full_rate(full_rate), .pll_path(pll_path),
    .low_bandwidth(low_bw));
  cbs_host i_host(.mclk(mclk), .sda_wire(sda_wire), .scl_drv(scl_drv),
    .sda_drv(sda_drv));
  // ====
  // expectations
  function logic [15:0] exp_out(input logic [7:0] m);
    logic s, p;
    logic [3:0] run;
    s = stop_n ^ inv;
    p = pdn_n ^ inv;
    run = (s & p) ? {en3 ^ inv, 2'b11, en0 ^ inv} : 4'h0;
    return {run, {4{(!s & m[6]) | (!p & m[7])}}, 5'h0, m[2] & bw_pin,
      m[1] & pll_pin, m[0]};
  endfunction
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ====
  // bus transfers, count never zero
  task hdr(input logic [7:0] a, input logic [7:0] o, input logic [7:0] n);
    i_host.frame_start;
    i_host.byte_io(a, 1'b1, rd, ack);
    chk(16'(ack), 16'h1);
    i_host.byte_io(o, 1'b1, rd, ack);
    chk(16'(ack), 16'h1);
    i_host.byte_io(n, 1'b1, rd, ack);
    chk(16'(ack), 16'h1);
  endtask
  task wr(input logic [7:0] o, input logic [7:0] n, input logic [7:0] v);
    hdr(8'hdc, o, n);
    repeat (n)
    begin
      i_host.byte_io(v, 1'b1, rd, ack);
      chk(16'(ack), 16'h1);
      v = ~v;
    end
    i_host.frame_stop;
  endtask
  task rdb(input logic [7:0] o, input logic [7:0] n);
    hdr(8'hdd, o, n);
    for (int k = 0; k < n; k++)
    begin
      i_host.byte_io(8'hff, k == n - 1, rd, ack);
      chk(16'(rd), (o + k == 0) ? 16'(mode) : 16'h0);
    end
    i_host.frame_stop;
  endtask
  initial
  begin
    repeat (90000) @(posedge mclk);
    n_fail++;
    give_verdict;
  end
  initial
  begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    mode = `CBS_MODE_RESET;
    chk(outs, exp_out(mode));
    rdb(8'h00, 8'h01);
    // foreign address left unanswered
    i_host.frame_start;
    i_host.byte_io(8'hde, 1'b1, rd, ack);
    chk(16'(ack), 16'h0);
    i_host.frame_stop;
    // second byte runs on to the empty offset
    wr(8'h00, 8'h02, 8'h38);
    mode = 8'h00;
    rdb(8'h00, 8'h02);
    rdb(8'h01, 8'h01);
    repeat (16)
    begin
      seed = next_rand(seed);
      wr(8'h00, 8'h01, seed[7:0]);
      mode = seed[7:0] & `CBS_MODE_WMASK;
      rdb(8'h00, 8'h01);
      {en0, en3, inv, stop_n, pdn_n, pll_pin, bw_pin} <= seed[14:8];
      repeat (5) @(posedge mclk);
      chk(outs, exp_out(mode));
      stop_n <= ~inv;
      pdn_n <= ~inv;
      repeat (5) @(posedge mclk);
    end
    // mid-run reset brings the mode byte back
    sys_rst <= 1'b1;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    mode = `CBS_MODE_RESET;
    chk(outs, exp_out(mode));
    rdb(8'h00, 8'h01);
    give_verdict;
  end
endmodule // clock_buffer_smbus_control_tb

// File: verilog/cbs_cfg.svh
// Summary of operation
// RL1: stop or power-down low turns outputs off
// RL2: host releases SMBus lines during power-down
// RL3: two active-high enables gate pairs 0, 3
// RL4: invert pin flips enables, stop, power-down
// RL5: pin chooses PLL or fan-out bypass
// RL6: pin selects PLL loop bandwidth
// RL7: slave only, indexed block read and write
// RL8: fixed address 1101110 plus direction bit
// RL9: start, address, offset, count, data, stop
// RL10: host never writes byte count zero
// RL11: byte 0 bit 0 divide by two, reset 1
// RL12: byte 0 bit 1 bypass or PLL, reset 1
// RL13: byte 0 bit 2 bandwidth, reset 1
// RL14: byte 0 bit 6 tristate on stop, reset 0
// RL15: byte 0 bit 7 tristate on power-down, reset 0
// RL16: register index advances after each data byte
// RL17: bits 3 to 5 read zero, ignore writes
`ifndef CBS_CFG_SVH
`define CBS_CFG_SVH
`define CBS_SLAVE_ADDR 7'h6e
`define CBS_OFS_MODE 8'h00
`define CBS_BIT_FULL_RATE 0
`define CBS_BIT_PLL_PATH 1
`define CBS_BIT_LOW_BW 2
`define CBS_BIT_TRI_STOP 6
`define CBS_BIT_TRI_PDN 7
`define CBS_MODE_RESET 8'h07
`define CBS_MODE_WMASK 8'hc7
`define CBS_PIN_RESET 6'h07
`define CBS_PLL_PIN_RESET 2'h3
`endif

// File: verilog/cbs_control.sv
`timescale 1ns/1ns
`include "cbs_cfg.svh"
module cbs_control
  import cbs_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // smbus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // control pins
  input wire logic enable_pair0,
  input wire logic enable_pair3,
  input wire logic control_polarity_invert,
  input wire logic clock_stop_n,
  input wire logic power_down_n,
  input wire logic pll_select_pin,
  input wire logic loop_bandwidth_select,
  // output controls
  output logic [3:0] pair_run,
  output logic [3:0] pair_float,
  output logic full_rate,
  output logic pll_path,
  output logic low_bandwidth
);
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [5:0] pin_s0;
    logic [5:0] pin_s1;
    logic [1:0] pll_s;
    logic scl_q;
    logic sda_q;
    cbs_state_t st;
    logic [7:0] sh;
    logic [3:0] bits;
    logic ack;
    logic rd;
    logic [7:0] idx;
    logic [7:0] cnt;
    logic [7:0] mode;
    logic sda_low;
  } cbs_reg_t;
  cbs_reg_t r, next_r;
  logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
  logic inv, oe0, oe3, stop_act, pdn_act;
  logic [7:0] rd_byte;
  logic [5:0] pins;
  assign pins = {enable_pair0, enable_pair3, control_polarity_invert,
                 clock_stop_n, power_down_n, loop_bandwidth_select};
  assign scl = r.scl_s[1];
  assign sda = r.sda_s[1];
  assign scl_rise = scl & ~r.scl_q;
  assign scl_fall = ~scl & r.scl_q;
  assign start_c = scl & r.scl_q & r.sda_q & ~sda;
  assign stop_c = scl & r.scl_q & ~r.sda_q & sda;
  // only byte 0 is implemented; reserved bits read zero
  assign rd_byte = (r.idx == `CBS_OFS_MODE) ?
                   (r.mode & `CBS_MODE_WMASK) : 8'h00; // RL17
  // =====================================================
  // pin control
  // =====================================================
  assign inv = r.pin_s1[3];
  assign oe0 = r.pin_s1[5] ^ inv; // RL3 RL4
  assign oe3 = r.pin_s1[4] ^ inv; // RL3 RL4
  assign stop_act = ~(r.pin_s1[2] ^ inv); // RL4
  assign pdn_act = ~(r.pin_s1[1] ^ inv); // RL4
  always_comb
  begin
    pair_run = {oe3, 2'b11, oe0}; // RL3
    if (stop_act || pdn_act)
    begin
      pair_run = 4'h0; // RL1
    end
    pair_float = 4'h0;
    if ((pdn_act && r.mode[`CBS_BIT_TRI_PDN]) ||
        (stop_act && r.mode[`CBS_BIT_TRI_STOP]))
    begin
      pair_float = 4'hf; // RL14 RL15
    end
  end
  assign full_rate = r.mode[`CBS_BIT_FULL_RATE]; // RL11
  // pin or register can pick the bypass path
  assign pll_path = r.mode[`CBS_BIT_PLL_PATH] & r.pll_s[1]; // RL5 RL12
  assign low_bandwidth = r.mode[`CBS_BIT_LOW_BW] &
                         r.pin_s1[0]; // RL6 RL13
  assign sda_out = 1'b0;
  assign sda_oe_n = ~r.sda_low;
  // =====================================================
  // smbus slave
  // =====================================================
  always_comb
  begin
    next_r = r;
    next_r.scl_s = {r.scl_s[0], scl_in};
    next_r.sda_s = {r.sda_s[0], sda_in};
    next_r.pin_s0 = pins;
    next_r.pin_s1 = r.pin_s0;
    next_r.pll_s = {r.pll_s[0], pll_select_pin};
    next_r.scl_q = scl;
    next_r.sda_q = sda;
    if (pdn_act)
    begin
      next_r.st = CBS_IDLE; // RL2
      next_r.sda_low = 1'b0;
    end
    else if (start_c)
    begin
      next_r.st = CBS_ADDR; // RL9
      next_r.bits = 4'h0;
      next_r.ack = 1'b0;
      next_r.sda_low = 1'b0;
    end
    else if (stop_c)
    begin
      next_r.st = CBS_IDLE;
      next_r.sda_low = 1'b0;
    end
    else if (r.st != CBS_IDLE && scl_rise && !r.ack)
    begin
      next_r.sh = {r.sh[6:0], sda};
      next_r.bits = r.bits + 4'h1;
    end
    else if (r.st != CBS_IDLE && scl_fall)
    begin
      next_r.sda_low = 1'b0;
      if (r.ack)
      begin
        // ack slot over
        next_r.ack = 1'b0;
        next_r.bits = 4'h0;
        if (r.st == CBS_RDATA)
        begin
          next_r.sh = rd_byte;
          next_r.sda_low = ~rd_byte[7];
        end
      end
      else if (r.bits == 4'h8)
      begin
        next_r.ack = 1'b1;
        next_r.sda_low = 1'b1;
        case (r.st)
          CBS_ADDR:
          begin
            if (r.sh[7:1] != `CBS_SLAVE_ADDR)
            begin
              next_r.st = CBS_IDLE; // RL8
              next_r.sda_low = 1'b0;
            end
            else
            begin
              next_r.rd = r.sh[0]; // RL8
              next_r.st = CBS_OFFSET;
            end
          end
          CBS_OFFSET:
          begin
            next_r.idx = r.sh;
            next_r.st = CBS_COUNT;
          end
          CBS_COUNT:
          begin
            next_r.cnt = r.sh;
            next_r.st = r.rd ? CBS_RDATA : CBS_WDATA; // RL7
          end
          CBS_WDATA:
          begin
            if (r.cnt == 8'h00)
            begin
              next_r.sda_low = 1'b0;
            end
            else
            begin
              if (r.idx == `CBS_OFS_MODE)
              begin
                next_r.mode = r.sh & `CBS_MODE_WMASK; // RL17
              end
              next_r.idx = r.idx + 8'h1; // RL16
              next_r.cnt = r.cnt - 8'h1;
            end
          end
          CBS_RDATA:
          begin
            // host drives ack; release and stop if nacked
            next_r.sda_low = 1'b0;
            next_r.idx = r.idx + 8'h1; // RL16
            if (r.cnt != 8'h00)
            begin
              next_r.cnt = r.cnt - 8'h1;
            end
          end
          default:
          begin
            next_r.st = CBS_IDLE;
          end
        endcase
      end
      else if (r.st == CBS_RDATA)
      begin
        // each falling edge drives the top bit, which the rising edge shifted up
        next_r.sda_low = ~r.sh[7];
      end
    end
    if (r.st == CBS_RDATA && r.ack && scl_rise && sda)
    begin
      next_r.st = CBS_IDLE;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.scl_s <= 2'b11;
      r.sda_s <= 2'b11;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
      r.pin_s0 <= `CBS_PIN_RESET;
      r.pin_s1 <= `CBS_PIN_RESET;
      r.pll_s <= `CBS_PLL_PIN_RESET;
      r.st <= CBS_IDLE;
      r.mode <= `CBS_MODE_RESET; // RL11 RL12 RL13 RL14 RL15
    end
    else
    begin
      r <= next_r;
    end
  end
  // =====================================================
  // checks
  // =====================================================
  property p_off_when_stopped;
    @(posedge mclk) disable iff (sys_rst)
      (stop_act || pdn_act) |-> pair_run == 4'h0;
  endproperty
  a_off_when_stopped: assert property (p_off_when_stopped) // RL1
    else $error("outputs run while stopped");
  property p_reserved_zero;
    @(posedge mclk) disable iff (sys_rst)
      r.mode[5:3] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // RL17
    else $error("reserved mode bits set");
  property p_idx_step;
    @(posedge mclk) disable iff (sys_rst)
      (r.st == CBS_WDATA && scl_fall && !r.ack && r.bits == 4'h8 &&
       r.cnt != 8'h00 && !pdn_act && !start_c && !stop_c)
      |=> r.idx == $past(r.idx) + 8'h1;
  endproperty
  a_idx_step: assert property (p_idx_step) // RL16
    else $error("index did not advance");
  property p_addr_reject;
    @(posedge mclk) disable iff (sys_rst)
      (r.st == CBS_ADDR && scl_fall && !r.ack && r.bits == 4'h8 &&
       r.sh[7:1] != `CBS_SLAVE_ADDR && !pdn_act && !start_c && !stop_c)
      |=> r.st == CBS_IDLE && !r.sda_low;
  endproperty
  a_addr_reject: assert property (p_addr_reject) // RL8
    else $error("foreign address acknowledged");
  property p_pdn_quiet;
    @(posedge mclk) disable iff (sys_rst)
      pdn_act |=> !r.sda_low;
  endproperty
  a_pdn_quiet: assert property (p_pdn_quiet) // RL2
    else $error("sda driven in power-down");
  property p_float_stop;
    @(posedge mclk) disable iff (sys_rst)
      (stop_act && r.mode[`CBS_BIT_TRI_STOP]) |-> pair_float == 4'hf;
  endproperty
  a_float_stop: assert property (p_float_stop) // RL14
    else $error("outputs not floated on stop");
  property p_float_pdn;
    @(posedge mclk) disable iff (sys_rst)
      (pdn_act && r.mode[`CBS_BIT_TRI_PDN]) |-> pair_float == 4'hf;
  endproperty
  a_float_pdn: assert property (p_float_pdn) // RL15
    else $error("outputs not floated on power-down");
  property p_run_clean;
    @(posedge mclk) disable iff (sys_rst)
      (!stop_act && !pdn_act) |-> pair_float == 4'h0 &&
      pair_run[2:1] == 2'b11;
  endproperty
  a_run_clean: assert property (p_run_clean) // RL3
    else $error("outputs off while running");
  property p_invert;
    @(posedge mclk) disable iff (sys_rst)
      (!stop_act && !pdn_act) |-> pair_run[0] == (r.pin_s1[5] ^ inv);
  endproperty
  a_invert: assert property (p_invert) // RL4
    else $error("enable sense wrong");
endmodule // cbs_control

// File: verilog/cbs_pkg.sv
package cbs_pkg;
  typedef enum logic [5:0] {
    CBS_IDLE = 6'h01,
    CBS_ADDR = 6'h02,
    CBS_OFFSET = 6'h04,
    CBS_COUNT = 6'h08,
    CBS_WDATA = 6'h10,
    CBS_RDATA = 6'h20
  } cbs_state_t;
endpackage
